// [rtl/nsa_pkg.sv]
// Notes on behaviour
// R01 - Data space uses low registers, 64 bytes.
// R02 - Program space joins registers: 14-bit data, 11-bit address.
// R03 - Program flash holds 2K words.
// R04 - Unused upper data bits read zero.
// R05 - Software keeps unused address bits zero.
// R06 - Every write erases then programs automatically.
// R07 - Internal timer sets write cycle length.
// R08 - Bit 7 selects space, frozen while busy.
// R09 - Read start is set-only, hardware clears.
// R10 - Data read lands next cycle.
// R11 - Program read lands after two cycles.
// R12 - No write without the enable gate.
// R13 - Write start is set-only, hardware clears.
// R14 - Done flag set per write; software clears.
// R15 - Data write runs while core continues.
// R16 - Program write stalls the core.
// R17 - Interrupts pend during program write stall.
// R18 - Reset during write sets abort flag.
// R19 - Warm reset keeps data, address, select.
// R20 - Unlock key port stores nothing.
// R21 - Gate must be set by earlier write.
// R22 - Software writes 55h then AAh first.
// R23 - Clearing gate never aborts a write.
// R24 - Done flag is bit 4, sticky.
// R25 - Unlock tracker needs consecutive key writes.
// R26 - Control bits 6 to 4 read zero.
package nsa_pkg;
    // =====================================================================
    // Register addresses.
    localparam logic [8:0] NSA_ADDR_CONTROL = 9'h18C;
    localparam logic [8:0] NSA_ADDR_KEY = 9'h18D;
    localparam logic [8:0] NSA_ADDR_DATA_LOW = 9'h10C;
    localparam logic [8:0] NSA_ADDR_ADDR_LOW = 9'h10D;
    localparam logic [8:0] NSA_ADDR_DATA_HIGH = 9'h10E;
    localparam logic [8:0] NSA_ADDR_ADDR_HIGH = 9'h10F;
    localparam logic [8:0] NSA_ADDR_FLAGS = 9'h00D;
    // =====================================================================
    // Field positions.
    localparam int NSA_BIT_READ = 0;
    localparam int NSA_BIT_WRITE = 1;
    localparam int NSA_BIT_GATE = 2;
    localparam int NSA_BIT_ABORT = 3;
    localparam int NSA_BIT_SPACE = 7;
    localparam int NSA_BIT_DONE = 4;
    // =====================================================================
    // Key values and sizes.
    localparam logic [7:0] NSA_KEY_FIRST = 8'h55;
    localparam logic [7:0] NSA_KEY_SECOND = 8'hAA;
    localparam int NSA_DATA_DEPTH = 64;
    localparam int NSA_PROG_DEPTH = 2048;
    localparam logic [7:0] NSA_DATA_HIGH_MASK = 8'h3F;
    localparam logic [7:0] NSA_CTRL_READ_MASK = 8'h8F;
    localparam int NSA_PROG_READ_CYCLES = 2;
    // Write cycle time in microseconds and clock rate in MHz.
    localparam int NSA_WRITE_TIME_US = 4000;
    localparam int NSA_CLK_MHZ = 100;
    localparam int NSA_WRITE_CYCLES = NSA_WRITE_TIME_US * NSA_CLK_MHZ;
    typedef enum logic [1:0] {NSA_UNLOCK_IDLE, NSA_UNLOCK_HALF, NSA_UNLOCK_ARMED} nsa_unlock_type;
endpackage : nsa_pkg

// [rtl/nsa_write_timer.sv]
`timescale 1ns/1ns
`default_nettype none
// =========================================================================
// Erase/write cycle timer.
module nsa_write_timer
    import nsa_pkg::*;
#(
    parameter int CYCLES = NSA_WRITE_CYCLES
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    initial
    begin
        if (CYCLES < 2)
        begin
            $error("nsa_write_timer: CYCLES too small");
        end
    end
    logic [31:0] count_q;
    // Counts the cycle down; a reset ends it without a done pulse.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            count_q <= 32'h0;
        end
        else if (start_in && count_q == 32'h0)
        begin
            count_q <= 32'(CYCLES); // R07
        end
        else if (count_q != 32'h0)
        begin
            count_q <= count_q - 32'h1;
        end
    end
    assign busy_out = (count_q != 32'h0);
    assign done_out = (count_q == 32'h1);
endmodule : nsa_write_timer
`default_nettype wire

// [rtl/nsa_controller.sv]
`timescale 1ns/1ns
`default_nettype none
// =========================================================================
// Self-access controller for data EEPROM and program flash.
module nsa_controller
    import nsa_pkg::*;
#(
    parameter int WRITE_CYCLES = NSA_WRITE_CYCLES,
    parameter int DATA_DEPTH = NSA_DATA_DEPTH,
    parameter int PROG_DEPTH = NSA_PROG_DEPTH
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic por_in,
    input wire logic [8:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic core_stall_out,
    output logic irq_hold_out
);
    initial
    begin
        if (DATA_DEPTH != NSA_DATA_DEPTH || PROG_DEPTH != NSA_PROG_DEPTH)
        begin
            $error("nsa_controller: unsupported memory depth");
        end
    end
    // =====================================================================
    // Register state.
    logic [7:0] data_low_q;
    logic [5:0] data_high_q;
    logic [7:0] addr_low_q;
    logic [7:0] addr_high_q;
    logic space_q;
    logic gate_q;
    logic read_q;
    logic write_q;
    logic abort_q;
    logic done_q;
    logic prog_read_q;
    logic [1:0] prog_cnt_q;
    logic write_prog_q;
    logic [7:0] wr_addr_low_q;
    logic [10:0] wr_addr_prog_q;
    logic [13:0] wr_word_q;
    nsa_unlock_type unlock_q;
    logic [7:0] data_mem [DATA_DEPTH];
    logic [13:0] prog_mem [PROG_DEPTH];
    logic timer_busy;
    logic timer_done;
    logic busy;
    logic ctrl_wr;
    logic key_wr;
    logic start_write;
    logic start_read;

    function automatic logic hit(input logic [8:0] a, input logic [8:0] r);
        hit = (a == r);
    endfunction : hit

    assign ctrl_wr = reg_wr_in && hit(reg_addr_in, NSA_ADDR_CONTROL);
    assign key_wr = reg_wr_in && hit(reg_addr_in, NSA_ADDR_KEY);
    assign busy = read_q || write_q || prog_read_q;
    // Write starts only with gate already set and unlock armed.
    assign start_write = ctrl_wr && reg_wdata_in[NSA_BIT_WRITE] && gate_q // R12 R21
        && unlock_q == NSA_UNLOCK_ARMED && !write_q && !prog_read_q; // R25
    assign start_read = ctrl_wr && reg_wdata_in[NSA_BIT_READ] && !busy;

    // =====================================================================
    // Write cycle timer.
    nsa_write_timer #(.CYCLES(WRITE_CYCLES)) u_timer
    (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(start_write),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );

    // Unlock tracker; the key port itself holds no value.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            unlock_q <= NSA_UNLOCK_IDLE;
        end
        else if (start_write)
        begin
            unlock_q <= NSA_UNLOCK_IDLE; // R25
        end
        else if (key_wr)
        begin
            unique case (unlock_q) // R20 R22
                NSA_UNLOCK_IDLE:
                begin
                    unlock_q <= (reg_wdata_in == NSA_KEY_FIRST) ? NSA_UNLOCK_HALF
                        : NSA_UNLOCK_IDLE;
                end
                NSA_UNLOCK_HALF:
                begin
                    unlock_q <= (reg_wdata_in == NSA_KEY_SECOND) ? NSA_UNLOCK_ARMED
                        : NSA_UNLOCK_IDLE;
                end
                NSA_UNLOCK_ARMED:
                begin
                    unlock_q <= NSA_UNLOCK_IDLE;
                end
            endcase
        end
        else if (reg_wr_in)
        begin
            unlock_q <= NSA_UNLOCK_IDLE; // R25
        end
    end

    // Data and address registers survive warm reset; only power-on clears.
    always_ff @(posedge clk_in)
    begin
        if (por_in)
        begin
            data_low_q <= 8'h00;
            data_high_q <= 6'h00;
            addr_low_q <= 8'h00;
            addr_high_q <= 8'h00;
            space_q <= 1'b0;
        end
        else if (!rst_in) // R19
        begin
            if (read_q && !space_q)
            begin
                data_low_q <= data_mem[addr_low_q[5:0]]; // R01 R10
            end
            else if (prog_read_q && prog_cnt_q == 2'(NSA_PROG_READ_CYCLES - 1))
            begin
                {data_high_q, data_low_q} <= prog_mem[{addr_high_q[2:0], addr_low_q}]; // R02 R11
            end
            else if (reg_wr_in && hit(reg_addr_in, NSA_ADDR_DATA_LOW))
            begin
                data_low_q <= reg_wdata_in;
            end
            if (reg_wr_in && hit(reg_addr_in, NSA_ADDR_DATA_HIGH))
            begin
                data_high_q <= reg_wdata_in[5:0] & NSA_DATA_HIGH_MASK[5:0];
            end
            if (reg_wr_in && hit(reg_addr_in, NSA_ADDR_ADDR_LOW))
            begin
                addr_low_q <= reg_wdata_in;
            end
            if (reg_wr_in && hit(reg_addr_in, NSA_ADDR_ADDR_HIGH))
            begin
                addr_high_q <= reg_wdata_in;
            end
            if (ctrl_wr && !busy && !start_write && !start_read)
            begin
                space_q <= reg_wdata_in[NSA_BIT_SPACE]; // R08
            end
        end
    end

    // Control bits: read, write, gate; set-only start bits.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            read_q <= 1'b0;
            prog_read_q <= 1'b0;
            prog_cnt_q <= 2'h0;
            write_q <= 1'b0;
            gate_q <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                gate_q <= reg_wdata_in[NSA_BIT_GATE]; // R23
            end
            if (start_read && !space_q)
            begin
                read_q <= 1'b1; // R09
            end
            else
            begin
                read_q <= 1'b0;
            end
            if (start_read && space_q)
            begin
                prog_read_q <= 1'b1;
                prog_cnt_q <= 2'h0;
            end
            else if (prog_read_q)
            begin
                prog_cnt_q <= prog_cnt_q + 2'h1;
                if (prog_cnt_q == 2'(NSA_PROG_READ_CYCLES - 1))
                begin
                    prog_read_q <= 1'b0; // R09
                end
            end
            if (start_write)
            begin
                write_q <= 1'b1; // R13
            end
            else if (timer_done)
            begin
                write_q <= 1'b0; // R13
            end
        end
    end

    // Latch write target at start, then erase and program on completion.
    always_ff @(posedge clk_in)
    begin
        if (start_write)
        begin
            write_prog_q <= space_q;
            wr_addr_low_q <= addr_low_q;
            wr_addr_prog_q <= {addr_high_q[2:0], addr_low_q}; // R02 R03
            wr_word_q <= {data_high_q, data_low_q};
        end
        if (write_q && timer_done)
        begin
            if (write_prog_q)
            begin
                prog_mem[wr_addr_prog_q] <= wr_word_q; // R06 R16
            end
            else
            begin
                data_mem[wr_addr_low_q[5:0]] <= wr_word_q[7:0]; // R06 R15
            end
        end
    end

    // Abort flag set by warm reset during a write; done flag sticky.
    always_ff @(posedge clk_in)
    begin
        if (por_in)
        begin
            abort_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (rst_in)
        begin
            if (write_q)
            begin
                abort_q <= 1'b1; // R18
            end
            done_q <= 1'b0;
        end
        else
        begin
            if (ctrl_wr)
            begin
                abort_q <= reg_wdata_in[NSA_BIT_ABORT];
            end
            if (write_q && timer_done)
            begin
                done_q <= 1'b1; // R14 R24
            end
            else if (reg_wr_in && hit(reg_addr_in, NSA_ADDR_FLAGS))
            begin
                done_q <= reg_wdata_in[NSA_BIT_DONE];
            end
        end
    end

    // Stall and interrupt hold during program writes.
    assign core_stall_out = write_q && write_prog_q; // R16
    assign irq_hold_out = write_q && write_prog_q; // R17

    // =====================================================================
    // Register read mux.
    always_comb
    begin
        reg_rdata_out = 8'h00;
        unique case (reg_addr_in)
            NSA_ADDR_CONTROL: reg_rdata_out = {space_q, 3'h0, abort_q, gate_q, write_q,
                read_q || prog_read_q} & NSA_CTRL_READ_MASK; // R26
            NSA_ADDR_DATA_LOW: reg_rdata_out = data_low_q;
            NSA_ADDR_DATA_HIGH: reg_rdata_out = {2'h0, data_high_q}; // R04
            NSA_ADDR_ADDR_LOW: reg_rdata_out = addr_low_q;
            NSA_ADDR_ADDR_HIGH: reg_rdata_out = addr_high_q;
            NSA_ADDR_FLAGS: reg_rdata_out = {3'h0, done_q, 4'h0};
            default: reg_rdata_out = 8'h00;
        endcase
    end

    // =====================================================================
    // Assertions.
    property p_data_read;
        @(posedge clk_in) disable iff (rst_in)
        start_read && !space_q |=> ##1 data_low_q == $past(data_mem[addr_low_q[5:0]]);
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read late"); // R10
    property p_prog_read;
        @(posedge clk_in) disable iff (rst_in)
        start_read && space_q |=> prog_read_q ##1 prog_read_q ##1 !prog_read_q;
    endproperty
    a_prog_read: assert property (p_prog_read) else $error("prog read length"); // R11
    property p_no_gate;
        @(posedge clk_in) disable iff (rst_in)
        ctrl_wr && !gate_q && !write_q |=> !write_q;
    endproperty
    a_no_gate: assert property (p_no_gate) else $error("write without gate"); // R12 R21
    property p_done;
        @(posedge clk_in) disable iff (rst_in)
        write_q && timer_done |=> done_q && !write_q;
    endproperty
    a_done: assert property (p_done) else $error("done not set"); // R14 R13
    property p_stall;
        @(posedge clk_in) disable iff (rst_in)
        start_write |=> write_q && core_stall_out == $past(space_q)
            && irq_hold_out == core_stall_out;
    endproperty
    a_stall: assert property (p_stall) else $error("bad stall"); // R16 R17
    property p_data_nostall;
        @(posedge clk_in) disable iff (rst_in)
        start_write && !space_q |=> write_q && !core_stall_out && !irq_hold_out;
    endproperty
    a_data_nostall: assert property (p_data_nostall) else $error("data stall"); // R15
    property p_space_hold;
        @(posedge clk_in) disable iff (rst_in || por_in)
        busy |=> $stable(space_q);
    endproperty
    a_space_hold: assert property (p_space_hold) else $error("space changed"); // R08
    property p_gate_clear;
        @(posedge clk_in) disable iff (rst_in)
        write_q && !timer_done |=> write_q;
    endproperty
    a_gate_clear: assert property (p_gate_clear) else $error("write cut"); // R23 R07
    property p_ctrl_zero;
        @(posedge clk_in) disable iff (rst_in)
        hit(reg_addr_in, NSA_ADDR_CONTROL) |-> reg_rdata_out[6:4] == 3'h0;
    endproperty
    a_ctrl_zero: assert property (p_ctrl_zero) else $error("ctrl bits"); // R26
    // The write bit never outlives the timer, so the cycle length is the timer's.
    property p_timer_busy;
        @(posedge clk_in) disable iff (rst_in)
        write_q |-> timer_busy;
    endproperty
    a_timer_busy: assert property (p_timer_busy) else $error("write without timer"); // R07
    // The program word lands in the data registers two cycles after the start.
    property p_prog_load;
        @(posedge clk_in) disable iff (rst_in)
        start_read && space_q |=> ##2 {data_high_q, data_low_q}
            == $past(prog_mem[{addr_high_q[2:0], addr_low_q}]);
    endproperty
    a_prog_load: assert property (p_prog_load) else $error("prog word wrong"); // R11 R02
    c_write: cover property (@(posedge clk_in) start_write);
    c_prog_write: cover property (@(posedge clk_in) core_stall_out);
    c_prog_read: cover property (@(posedge clk_in) start_read && space_q);
    c_abort: cover property (@(posedge clk_in) rst_in && write_q);
endmodule : nsa_controller
`default_nettype wire

// [bench/nsa_core_model.sv]
`timescale 1ns/1ns
`default_nettype none
// =========================================================================
// Processor core model issuing special-register reads and writes.
module nsa_core_model
    import nsa_pkg::*;
(
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic [7:0] rdata_in,
    output logic [8:0] addr_out,
    output logic wr_out,
    output logic [7:0] wdata_out
);
    // The bus starts idle so nothing is taken during reset.
    initial
    begin
        addr_out = 9'h000;
        wr_out = 1'b0;
        wdata_out = 8'h00;
    end

    // A stalled core issues nothing, so every access first waits for the stall to lift.
    task automatic wait_run();
        while (stall_in !== 1'b0)
        begin
            @(negedge clk_in);
        end
    endtask : wait_run

    // One register write: strobe held for exactly one rising edge.
    task automatic wr(input logic [8:0] addr, input logic [7:0] data);
        wait_run();
        @(negedge clk_in);
        addr_out = addr;
        wdata_out = data;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
    endtask : wr

    // One register read; the answer is combinational and taken once settled.
    task automatic rd(input logic [8:0] addr, output logic [7:0] data);
        wait_run();
        @(negedge clk_in);
        addr_out = addr;
        #1;
        data = rdata_in;
    endtask : rd

    // Key pair on consecutive writes, then the control write with the control byte as given.
    task automatic start_write(input logic [7:0] ctrl);
        wr(NSA_ADDR_KEY, NSA_KEY_FIRST);
        wr(NSA_ADDR_KEY, NSA_KEY_SECOND);
        wr(NSA_ADDR_CONTROL, ctrl);
    endtask : start_write
endmodule : nsa_core_model
`default_nettype wire

// [bench/test_nvm_self_access_controller.sv]
`timescale 1ns/1ns
`default_nettype none
// =========================================================================
// Testbench for the self-access controller.
module test_nvm_self_access_controller;
    import nsa_pkg::*;
    localparam int WCYC = 8;
    logic clk_in;
    logic rst_in;
    logic por_in;
    logic reg_wr;
    logic core_stall;
    logic irq_hold;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] rv;
    int err_count;
    int samples_checked;

    nsa_controller #(.WRITE_CYCLES(WCYC)) u_nsa_controller (
        .clk_in(clk_in), .rst_in(rst_in), .por_in(por_in), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
        .core_stall_out(core_stall), .irq_hold_out(irq_hold));

    nsa_core_model u_nsa_core_model (
        .clk_in(clk_in), .stall_in(core_stall), .rdata_in(reg_rdata),
        .addr_out(reg_addr), .wr_out(reg_wr), .wdata_out(reg_wdata));

    // Free-running 100 MHz clock.
    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // =====================================================================
    // Shared helpers.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic w(input logic [8:0] a, input logic [7:0] d);
        u_nsa_core_model.wr(a, d);
    endtask : w

    task automatic rc(input logic [8:0] a, input logic [7:0] exp, input string msg);
        u_nsa_core_model.rd(a, rv);
        chk(rv, exp, msg);
    endtask : rc

    // Polls the done flag under a bound; a late or missing flag is a mismatch.
    task automatic wait_done();
        int n;
        n = 0;
        rv = 8'h00;
        while (rv[NSA_BIT_DONE] !== 1'b1 && n < 40)
        begin
            u_nsa_core_model.rd(NSA_ADDR_FLAGS, rv);
            n++;
        end
        chk(rv, 8'h10, "done flag after write");
    endtask : wait_done

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Watchdog sized well beyond the few hundred cycles the tests need.
    initial
    begin
        #40000;
        err_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        wrap_up();
    end

    // =====================================================================
    // Test sequence.
    initial
    begin
        err_count = 0;
        samples_checked = 0;
        rst_in = 1'b1;
        por_in = 1'b1;
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        por_in = 1'b0;
        rc(NSA_ADDR_CONTROL, 8'h00, "control after power-on");
        rc(NSA_ADDR_FLAGS, 8'h00, "flags after power-on");
        w(NSA_ADDR_DATA_HIGH, 8'hFF);
        rc(NSA_ADDR_DATA_HIGH, 8'h3F, "data high upper bits");
        w(NSA_ADDR_CONTROL, 8'h70);
        rc(NSA_ADDR_CONTROL, 8'h00, "control bits 6 to 4");
        w(NSA_ADDR_KEY, NSA_KEY_FIRST);
        rc(NSA_ADDR_KEY, 8'h00, "key port readback");
        $display("test fields done");
        // Refused starts: gate in same write, broken key pair, gate clear.
        w(NSA_ADDR_ADDR_LOW, 8'h3F);
        w(NSA_ADDR_DATA_LOW, 8'hA5);
        u_nsa_core_model.start_write(8'h06);
        rc(NSA_ADDR_CONTROL, 8'h04, "gate and write together");
        w(NSA_ADDR_KEY, NSA_KEY_FIRST);
        w(NSA_ADDR_ADDR_LOW, 8'h3F);
        w(NSA_ADDR_KEY, NSA_KEY_SECOND);
        w(NSA_ADDR_CONTROL, 8'h06);
        rc(NSA_ADDR_CONTROL, 8'h04, "broken key pair");
        w(NSA_ADDR_CONTROL, 8'h00);
        u_nsa_core_model.start_write(8'h02);
        repeat (WCYC + 4) @(negedge clk_in);
        rc(NSA_ADDR_CONTROL, 8'h00, "write without gate");
        rc(NSA_ADDR_FLAGS, 8'h00, "no done without write");
        $display("test refused done");
        // Data write at the top byte; core keeps running.
        w(NSA_ADDR_CONTROL, 8'h04);
        u_nsa_core_model.start_write(8'h06);
        rc(NSA_ADDR_CONTROL, 8'h06, "write in progress");
        chk({6'h00, irq_hold, core_stall}, 8'h00, "no stall on data write");
        rc(NSA_ADDR_FLAGS, 8'h00, "done not early");
        w(NSA_ADDR_CONTROL, 8'h80);
        rc(NSA_ADDR_CONTROL, 8'h02, "gate cleared, space frozen");
        wait_done();
        rc(NSA_ADDR_CONTROL, 8'h00, "write bit cleared");
        rc(NSA_ADDR_FLAGS, 8'h10, "done flag sticky");
        w(NSA_ADDR_FLAGS, 8'h00);
        rc(NSA_ADDR_FLAGS, 8'h00, "done flag cleared");
        w(NSA_ADDR_DATA_LOW, 8'h00);
        w(NSA_ADDR_CONTROL, 8'h01);
        rc(NSA_ADDR_DATA_LOW, 8'hA5, "data read next cycle");
        rc(NSA_ADDR_CONTROL, 8'h00, "read bit cleared");
        // Overwrite the same byte to see the erase before program.
        w(NSA_ADDR_DATA_LOW, 8'h5A);
        w(NSA_ADDR_CONTROL, 8'h04);
        u_nsa_core_model.start_write(8'h06);
        wait_done();
        w(NSA_ADDR_FLAGS, 8'h00);
        w(NSA_ADDR_DATA_LOW, 8'h00);
        w(NSA_ADDR_CONTROL, 8'h01);
        rc(NSA_ADDR_DATA_LOW, 8'h5A, "overwritten byte");
        $display("test data write done");
        // Program write at the last word; the core stalls.
        w(NSA_ADDR_ADDR_HIGH, 8'h07);
        w(NSA_ADDR_ADDR_LOW, 8'hFF);
        w(NSA_ADDR_DATA_HIGH, 8'h2B);
        w(NSA_ADDR_DATA_LOW, 8'h3C);
        w(NSA_ADDR_CONTROL, 8'h84);
        u_nsa_core_model.start_write(8'h86);
        @(negedge clk_in);
        chk({6'h00, irq_hold, core_stall}, 8'h03, "stall and hold");
        wait_done();
        chk({6'h00, irq_hold, core_stall}, 8'h00, "stall released");
        w(NSA_ADDR_FLAGS, 8'h00);
        w(NSA_ADDR_DATA_HIGH, 8'h00);
        w(NSA_ADDR_DATA_LOW, 8'h00);
        w(NSA_ADDR_CONTROL, 8'h81);
        rc(NSA_ADDR_DATA_HIGH, 8'h00, "program word not before second cycle");
        rc(NSA_ADDR_DATA_HIGH, 8'h2B, "program word high");
        rc(NSA_ADDR_DATA_LOW, 8'h3C, "program word low");
        w(NSA_ADDR_CONTROL, 8'h00);
        w(NSA_ADDR_ADDR_LOW, 8'h3F);
        w(NSA_ADDR_CONTROL, 8'h01);
        rc(NSA_ADDR_DATA_LOW, 8'h5A, "data space ignores high regs");
        $display("test program write done");
        // Warm reset in mid program write.
        w(NSA_ADDR_CONTROL, 8'h84);
        u_nsa_core_model.start_write(8'h86);
        repeat (3) @(negedge clk_in);
        rst_in = 1'b1;
        @(negedge clk_in);
        rst_in = 1'b0;
        chk({6'h00, irq_hold, core_stall}, 8'h00, "stall after reset");
        rc(NSA_ADDR_CONTROL, 8'h88, "abort flag, space kept");
        rc(NSA_ADDR_ADDR_LOW, 8'h3F, "address kept");
        rc(NSA_ADDR_DATA_LOW, 8'h5A, "data kept");
        repeat (WCYC + 4) @(negedge clk_in);
        rc(NSA_ADDR_FLAGS, 8'h00, "aborted write never done");
        $display("test abort done");
        // Power-on reset clears the registers but leaves the memory contents.
        rst_in = 1'b1;
        por_in = 1'b1;
        @(negedge clk_in);
        rst_in = 1'b0;
        por_in = 1'b0;
        rc(NSA_ADDR_CONTROL, 8'h00, "control after power-on reset");
        rc(NSA_ADDR_ADDR_LOW, 8'h00, "address cleared by power-on");
        rc(NSA_ADDR_DATA_LOW, 8'h00, "data cleared by power-on");
        w(NSA_ADDR_CONTROL, 8'h08);
        rc(NSA_ADDR_CONTROL, 8'h08, "abort bit set by software");
        w(NSA_ADDR_CONTROL, 8'h00);
        rc(NSA_ADDR_CONTROL, 8'h00, "abort bit cleared by software");
        w(NSA_ADDR_ADDR_LOW, 8'h3F);
        w(NSA_ADDR_CONTROL, 8'h01);
        rc(NSA_ADDR_DATA_LOW, 8'h5A, "memory kept over power-on");
        $display("test power-on done");
        wrap_up();
    end
endmodule : test_nvm_self_access_controller
`default_nettype wire
